// [hw/mocl_top.sv]
// Overload current limiter with category-based parameter persistence
`timescale 1ns/1ps
module mocl_top
	import mocl_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYC_DEF // Clock cycles per millisecond
)
(
	input  wire logic          mclk,                   // System clock
	input  wire logic          reset,                  // Sync reset, high
	input  wire logic          factory_load,           // Fill store w/ factory
	input  wire logic          fw_update,              // Firmware restart
	input  wire logic          par_wr,                 // Parameter write
	input  wire logic [3:0]    par_id,                 // Parameter slot
	input  wire logic [PW-1:0] par_wdata,              // Parameter value
	input  wire logic [3:0]    par_rd_id,              // Slot to read back
	input  wire logic          save_req,               // Save category pulse
	input  wire logic [2:0]    save_cat,               // Category to save
	input  wire logic [PW-1:0] meas_current_ma,        // Motor current mag.
	output logic      [PW-1:0] par_rdata,              // Read-back value
	output logic               save_done,              // Save finished
	output logic               save_refused,           // Save rejected
	output logic      [31:0]   threshold_a2ms,         // Threshold A^2 ms
	output logic      [31:0]   accumulated_load_value, // Load A^2 ms
	output logic      [PW-1:0] applied_current_limit,  // Limit in mA
	output logic               limit_engaged,          // Rated clamp on
	output logic               protect_status          // 1 active, 0 off
);

	// -----------------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------------
	mocl_cfg_if cfg ();

	logic [PW-1:0] live_q [NUM_PAR];
	logic [PW-1:0] nv_q   [NUM_PAR];
	logic [PW-1:0] rdata_q;
	logic          save_ok;
	logic          save_done_q;
	logic          save_refused_q;
	logic [15:0]   tick_cnt_q;
	logic          tick;
	logic [31:0]   meas_sq;
	logic [31:0]   rated_sq;
	logic [AW:0]   acc_sum;
	logic [AW-1:0] acc_q;
	logic [AW-1:0] acc_d;
	logic          engaged_q;
	logic          engaged_d;
	logic [PW-1:0] limit_q;
	logic          status_q;
	logic [31:0]   thr_out_q;
	logic [31:0]   acc_out_q;

	// -----------------------------------------------------------------
	// Parameter store
	// -----------------------------------------------------------------

	// A save names one category; anything else is turned away
	assign save_ok = (save_cat >= 3'(CAT_COMM))
		&& (save_cat <= 3'(CAT_NET));

	generate
		for (genvar g = 0; g < NUM_PAR; g++) begin : g_slot
			// Nonvolatile copy: untouched by reset and firmware update
			always_ff @(posedge mclk) begin
				if (factory_load) begin
					nv_q[g] <= FACTORY_VALS[g*PW +: PW];
				end else if (save_req && save_ok
					&& (mocl_cat_of(4'(g)) == mocl_cat_e'(save_cat))
					&& (mocl_cat_of(4'(g)) != CAT_NONE)) begin
					nv_q[g] <= live_q[g];
				end
			end

			// Working copy: reloaded on every restart, from the store or, for uncategorised slots, from the factory values
			always_ff @(posedge mclk) begin
				if (reset || fw_update) begin
					if (mocl_cat_of(4'(g)) == CAT_NONE) begin
						live_q[g] <= FACTORY_VALS[g*PW +: PW];
					end else begin
						live_q[g] <= nv_q[g];
					end
				end else if (par_wr && (par_id == 4'(g))) begin
					live_q[g] <= par_wdata;
				end
			end
		end
	endgenerate

	// Save completion or refusal, one cycle after the request
	always_ff @(posedge mclk) begin
		if (reset) begin
			save_done_q    <= 1'b0;
			save_refused_q <= 1'b0;
		end else begin
			save_done_q    <= save_req && save_ok;
			save_refused_q <= save_req && !save_ok;
		end
	end

	// Read-back; the customer slot is only ever stored and returned
	always_ff @(posedge mclk) begin
		if (reset) begin
			rdata_q <= '0;
		end else if (par_rd_id < 4'(NUM_PAR)) begin
			rdata_q <= live_q[par_rd_id];
		end else begin
			rdata_q <= '0;
		end
	end

	// Only drive-relevant slots reach the limiter; customer slot is not
	assign cfg.ceil_ma     = live_q[PAR_CEIL];
	assign cfg.rated_ma    = live_q[PAR_RATED];
	assign cfg.peak_pm     = live_q[PAR_PEAK];
	assign cfg.pdur_ms     = live_q[PAR_PDUR];
	assign cfg.closed_loop = live_q[PAR_SUBMODE][SUBMODE_CLOSED_BIT];

	// -----------------------------------------------------------------
	// Limit derivation
	// -----------------------------------------------------------------
	mocl_limit_calc u_calc (
		.mclk  (mclk),
		.reset (reset),
		.cfg   (cfg.calc)
	);

	// -----------------------------------------------------------------
	// Millisecond tick
	// -----------------------------------------------------------------

	// 16-bit counter; TICK_CYC above 65536 is not supported
	always_ff @(posedge mclk) begin
		if (reset || (tick_cnt_q == 16'(TICK_CYC - 1))) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;
		end
	end

	assign tick = (tick_cnt_q == 16'(TICK_CYC - 1));

	// -----------------------------------------------------------------
	// Thermal load accumulator
	// -----------------------------------------------------------------
	assign meas_sq  = 32'(meas_current_ma) * 32'(meas_current_ma);
	assign rated_sq = 32'(cfg.rated_eff) * 32'(cfg.rated_eff);
	assign acc_sum  = {1'b0, acc_q} + (AW+1)'(meas_sq - rated_sq);

	// Above rated the load grows, below it cools, floor at zero
	always_comb begin
		acc_d = acc_q;
		if (!cfg.cond_ok) begin
			acc_d = '0;
		end else if (tick) begin
			if (meas_sq >= rated_sq) begin
				acc_d = acc_sum[AW] ? '1 : acc_sum[AW-1:0];
			end else if (acc_q > AW'(rated_sq - meas_sq)) begin
				acc_d = acc_q - AW'(rated_sq - meas_sq);
			end else begin
				acc_d = '0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			acc_q <= '0;
		end else begin
			acc_q <= acc_d;
		end
	end

	// -----------------------------------------------------------------
	// Clamp decision
	// -----------------------------------------------------------------

	// Reaching the limit sets the clamp; while active it releases only once cooled
	// to zero, which avoids chattering around the threshold
	always_comb begin
		engaged_d = engaged_q;
		if (!cfg.cond_ok) begin
			engaged_d = 1'b0;
		end else if (acc_d >= cfg.thr_int) begin
			engaged_d = 1'b1;
		end else if (acc_d == '0) begin
			engaged_d = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			engaged_q <= 1'b0;
		end else begin
			engaged_q <= engaged_d;
		end
	end

	// Applied limit follows the same edge as the load crossing
	always_ff @(posedge mclk) begin
		if (reset) begin
			limit_q <= '0;
		end else if (!cfg.cond_ok || engaged_d) begin
			limit_q <= cfg.rated_eff;
		end else begin
			limit_q <= cfg.peak_eff;
		end
	end

	// -----------------------------------------------------------------
	// Status and reported values
	// -----------------------------------------------------------------

	// Status reflects the activation conditions
	always_ff @(posedge mclk) begin
		if (reset) begin
			status_q <= 1'b0;
		end else begin
			status_q <= cfg.cond_ok;
		end
	end

	// Internal sums are in mA^2 ms; scale down to A^2 ms for reporting
	always_ff @(posedge mclk) begin
		if (reset) begin
			thr_out_q <= '0;
			acc_out_q <= '0;
		end else begin
			thr_out_q <= 32'(cfg.thr_int / AW'(MA2_PER_A2));
			acc_out_q <= 32'(acc_q / AW'(MA2_PER_A2));
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign par_rdata              = rdata_q;
	assign save_done              = save_done_q;
	assign save_refused           = save_refused_q;
	assign threshold_a2ms         = thr_out_q;
	assign accumulated_load_value = acc_out_q;
	assign applied_current_limit  = limit_q;
	assign limit_engaged          = engaged_q;
	assign protect_status         = status_q;

endmodule : mocl_top

// [hw/mocl_pkg.sv]
// Constants, types and helpers for the motor overload current limiter
//
// Behaviour
// - Protection only in closed-loop submode
// - Absolute current ceiling caps every limit
// - Peak setting in tenths of rated percent
// - Peak duration in ms forms thermal limit
// - Report threshold in ampere-squared milliseconds
// - Report accumulated load, compare with threshold
// - Report applied current limit in mA
// - Protection needs peak above rated current
// - Status shows 0 inactive, 1 active
// - Thermal limit from rated, peak, duration
// - Peak current allowed until limit reached
// - At limit drop at once to rated
// - Effective peak clamped to current ceiling
// - Saved parameters reload at reset
// - Saved values survive firmware update
// - Save whole categories only
// - Six categories of savable parameters
// - Uncategorised parameters are never saved
// - Customer parameters stored, never used
package mocl_pkg;

	// -----------------------------------------------------------------
	// Parameter categories and identifiers
	// -----------------------------------------------------------------
	typedef enum logic [2:0] {
		CAT_NONE, CAT_COMM, CAT_APP, CAT_CUST, CAT_DRIVE, CAT_TUNE, CAT_NET
	} mocl_cat_e;

	localparam int         NUM_PAR     = 10;
	localparam int         PW          = 16;
	localparam int         AW          = 48;
	localparam logic [3:0] PAR_CEIL    = 4'h0;
	localparam logic [3:0] PAR_RATED   = 4'h1;
	localparam logic [3:0] PAR_PDUR    = 4'h2;
	localparam logic [3:0] PAR_PEAK    = 4'h3;
	localparam logic [3:0] PAR_SUBMODE = 4'h4;
	localparam logic [3:0] PAR_CUST    = 4'h5;
	localparam logic [3:0] PAR_COMM    = 4'h6;
	localparam logic [3:0] PAR_APP     = 4'h7;
	localparam logic [3:0] PAR_NET     = 4'h8;
	localparam logic [3:0] PAR_STATUS  = 4'h9;
	localparam int         SUBMODE_CLOSED_BIT = 0;

	// Factory contents, slot n at bits [16n+15:16n]; plain defaults
	localparam logic [NUM_PAR*PW-1:0] FACTORY_VALS = {
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h03E8, 16'h03E8, 16'h0BB8
	};

	// -----------------------------------------------------------------
	// Scaling and timing
	// -----------------------------------------------------------------
	localparam longint PERMILLE_DIV  = 1000;
	localparam longint MA2_PER_A2    = 1000000;
	localparam int     TICK_NS       = 1000000;
	localparam int     CLK_PERIOD_NS = 50;
	localparam int     TICK_CYC_DEF  = TICK_NS / CLK_PERIOD_NS;

	// Category owning each parameter slot
	function automatic mocl_cat_e mocl_cat_of(input logic [3:0] id);
		case (id)
			PAR_CEIL, PAR_RATED, PAR_PDUR: mocl_cat_of = CAT_TUNE;
			PAR_PEAK, PAR_SUBMODE:         mocl_cat_of = CAT_DRIVE;
			PAR_CUST:                      mocl_cat_of = CAT_CUST;
			PAR_COMM:                      mocl_cat_of = CAT_COMM;
			PAR_APP:                       mocl_cat_of = CAT_APP;
			PAR_NET:                       mocl_cat_of = CAT_NET;
			default:                       mocl_cat_of = CAT_NONE;
		endcase
	endfunction : mocl_cat_of

endpackage : mocl_pkg

// [hw/mocl_cfg_if.sv]
// Interface carrying configuration and derived limits between modules
`timescale 1ns/1ps
interface mocl_cfg_if;
	import mocl_pkg::*;
	logic [PW-1:0] ceil_ma;
	logic [PW-1:0] rated_ma;
	logic [PW-1:0] peak_pm;
	logic [PW-1:0] pdur_ms;
	logic          closed_loop;
	logic [PW-1:0] rated_eff;
	logic [PW-1:0] peak_eff;
	logic [AW-1:0] thr_int;
	logic          cond_ok;
	modport store (output ceil_ma, rated_ma, peak_pm, pdur_ms, closed_loop);
	modport calc  (input ceil_ma, rated_ma, peak_pm, pdur_ms, closed_loop,
	               output rated_eff, peak_eff, thr_int, cond_ok);
	modport core  (input rated_eff, peak_eff, thr_int, cond_ok);
endinterface : mocl_cfg_if

// [hw/mocl_limit_calc.sv]
// Derivation of effective currents and thermal limit from configuration
`timescale 1ns/1ps
module mocl_limit_calc
	import mocl_pkg::*;
(
	input wire logic mclk,  // System clock
	input wire logic reset, // Synchronous reset, active high
	mocl_cfg_if.calc cfg    // Configuration in, derived limits out
);

	logic [31:0]   peak_raw;
	logic [PW-1:0] peak_ma;
	logic [PW-1:0] rated_eff_q;
	logic [PW-1:0] peak_eff_q;
	logic [AW-1:0] thr_q;
	logic          cond_q;
	logic [31:0]   diff_sq;

	// -----------------------------------------------------------------
	// Peak current in mA from a per-mille share of rated
	// -----------------------------------------------------------------
	assign peak_raw = 32'((longint'(cfg.rated_ma) * cfg.peak_pm)
		/ PERMILLE_DIV);
	assign peak_ma = (peak_raw > 32'(cfg.ceil_ma)) ? cfg.ceil_ma
		: peak_raw[PW-1:0];

	// Clamp both currents; no produced limit may pass the ceiling
	always_ff @(posedge mclk) begin
		if (reset) begin
			rated_eff_q <= '0;
			peak_eff_q  <= '0;
		end else begin
			rated_eff_q <= (cfg.rated_ma > cfg.ceil_ma) ? cfg.ceil_ma
				: cfg.rated_ma;
			peak_eff_q  <= peak_ma;
		end
	end

	// -----------------------------------------------------------------
	// Thermal limit in mA^2 ms, second pipeline stage
	// -----------------------------------------------------------------
	assign diff_sq = (32'(peak_eff_q) * 32'(peak_eff_q))
		- (32'(rated_eff_q) * 32'(rated_eff_q));

	// Activation needs closed loop, peak above rated and a duration
	always_ff @(posedge mclk) begin
		if (reset) begin
			thr_q  <= '0;
			cond_q <= 1'b0;
		end else begin
			thr_q  <= AW'(diff_sq) * AW'(cfg.pdur_ms);
			cond_q <= cfg.closed_loop
				&& (peak_eff_q > rated_eff_q)
				&& (cfg.pdur_ms != '0);
		end
	end

	assign cfg.rated_eff = rated_eff_q;
	assign cfg.peak_eff  = peak_eff_q;
	assign cfg.thr_int   = thr_q;
	assign cfg.cond_ok   = cond_q;

endmodule : mocl_limit_calc

// [sim/mocl_top_sva.sv]
// Port-level assertion checker for the overload current limiter
`timescale 1ns/1ps
module mocl_top_chk
	import mocl_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYC_DEF // Cycles per ms tick
)
(
	input wire logic          mclk,                   // Clock
	input wire logic          reset,                  // Sync reset
	input wire logic          save_req,               // Save pulse
	input wire logic [2:0]    save_cat,               // Save category
	input wire logic          save_done,              // Save finished
	input wire logic          save_refused,           // Save rejected
	input wire logic [31:0]   threshold_a2ms,         // Threshold
	input wire logic [31:0]   accumulated_load_value, // Load value
	input wire logic [PW-1:0] applied_current_limit,  // Limit in mA
	input wire logic          limit_engaged,          // Rated clamp
	input wire logic          protect_status          // Active flag
);
	// -----------------------------------------------------------------
	// Save handshake
	// -----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	AST_SAVE_OK: assert property (
		save_req && save_cat inside {[3'h1:3'h6]} |=> save_done)
		else $error("Category save did not complete");
	AST_SAVE_REF: assert property (
		save_req && !(save_cat inside {[3'h1:3'h6]}) |=> save_refused)
		else $error("Bad category save was not refused");
	AST_SAVE_CAUSE: assert property (
		save_done || save_refused |-> $past(save_req))
		else $error("Save answer without a request");
	AST_SAVE_EXCL: assert property (
		!(save_done && save_refused))
		else $error("Save both done and refused");
	// -----------------------------------------------------------------
	// Limiter; reported values lag the accumulator by one edge
	// -----------------------------------------------------------------
	AST_INACT_ZERO: assert property (
		(!protect_status)[*4] |-> accumulated_load_value == 32'h0
		&& !limit_engaged) else $error("Inactive limiter holds load");
	// Clamp and limit register share one edge, so the limit must drop
	AST_ENGAGE_RATED: assert property (
		$rose(limit_engaged) |->
		applied_current_limit < $past(applied_current_limit))
		else $error("Limit did not drop when clamp engaged");
	AST_ENGAGE_THR: assert property (
		$rose(limit_engaged) |=> accumulated_load_value >= threshold_a2ms)
		else $error("Clamp engaged below threshold");
	AST_RELEASE: assert property (
		$fell(limit_engaged) |=> accumulated_load_value == 32'h0)
		else $error("Clamp released with load left");
endmodule : mocl_top_chk

bind mocl_top mocl_top_chk #(.TICK_CYC(TICK_CYC)) u_chk (
	.mclk(mclk), .reset(reset), .save_req(save_req),
	.save_cat(save_cat), .save_done(save_done),
	.save_refused(save_refused), .threshold_a2ms(threshold_a2ms),
	.accumulated_load_value(accumulated_load_value),
	.applied_current_limit(applied_current_limit),
	.limit_engaged(limit_engaged), .protect_status(protect_status));

// [sim/mocl_motor_model.sv]
// Behavioural motor current regulator and power stage
`timescale 1ns/1ps
module mocl_motor_model
	import mocl_pkg::*;
(
	input  wire logic          mclk,      // Clock
	input  wire logic [PW-1:0] demand_ma, // Current the load asks for
	input  wire logic [PW-1:0] limit_ma,  // Limit imposed by the block
	output logic      [PW-1:0] meas_ma    // Measured magnitude
);
	// Regulator settles in one cycle and never passes the imposed limit
	always_ff @(posedge mclk) begin
		meas_ma <= (demand_ma > limit_ma) ? limit_ma : demand_ma;
	end
endmodule : mocl_motor_model

// [sim/mocl_top_tb.sv]
// Self-checking bench for the overload current limiter
`timescale 1ns/1ps
module mocl_top_tb;
	import mocl_pkg::*;
	localparam int TK = 8; // Short ms tick keeps the run brief
	logic          mclk = 1'b0, reset = 1'b1, factory_load = 1'b1;
	logic          fw_update = 1'b0, par_wr = 1'b0, save_req = 1'b0;
	logic [3:0]    par_id = 4'h0, par_rd_id = 4'h0;
	logic [2:0]    save_cat = 3'h0;
	logic [PW-1:0] par_wdata = 16'h0000, demand = 16'h0000;
	logic [PW-1:0] meas, par_rdata, lim, v, pa [10];
	logic [31:0]   thr, acc;
	logic          save_done, save_refused, eng, stat;
	int            n_fail = 0, tests_run = 0, seed = 62, i, n;
	int            r, p, d, c, s, el, act;
	longint        et;
	int            tab [5][5] = '{'{1000, 2000, 10, 3000, 1},
		'{1000, 2000, 10, 1500, 1}, '{1000, 1000, 10, 3000, 1},
		'{1000, 2000, 0, 3000, 1}, '{1000, 2000, 10, 3000, 0}};

	// 20 MHz clock
	always #25 mclk = ~mclk;

	mocl_top #(.TICK_CYC(TK)) dut (
		.mclk(mclk), .reset(reset), .factory_load(factory_load),
		.fw_update(fw_update), .par_wr(par_wr), .par_id(par_id),
		.par_wdata(par_wdata), .par_rd_id(par_rd_id),
		.save_req(save_req), .save_cat(save_cat),
		.meas_current_ma(meas), .par_rdata(par_rdata),
		.save_done(save_done), .save_refused(save_refused),
		.threshold_a2ms(thr), .accumulated_load_value(acc),
		.applied_current_limit(lim), .limit_engaged(eng),
		.protect_status(stat));
	mocl_motor_model u_motor (.mclk(mclk), .demand_ma(demand),
		.limit_ma(lim), .meas_ma(meas));

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	task automatic chk(input string nm, input logic [47:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s exp %0h got %0h", nm, exp, got);
		end
	endtask : chk

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	// Expected limit, status and reported threshold of r, p, d, c, s
	function automatic void calc();
		int re, pe;
		re = (r < c) ? r : c;
		pe = (r * p / 1000 < c) ? r * p / 1000 : c;
		act = (s != 0 && pe > re && d != 0);
		el = (act != 0) ? pe : re;
		et = (longint'(pe * pe - re * re) * d) / 1000000;
	endfunction : calc

	task automatic wr(input logic [3:0] id, input logic [15:0] val);
		@(posedge mclk);
		par_wr <= 1'b1;
		par_id <= id;
		par_wdata <= val;
		@(posedge mclk);
		par_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] id, output logic [15:0] val);
		@(posedge mclk);
		par_rd_id <= id;
		repeat (2) @(posedge mclk);
		#1 val = par_rdata;
	endtask : rd

	task automatic sv(input logic [2:0] cat);
		@(posedge mclk);
		save_req <= 1'b1;
		save_cat <= cat;
		@(posedge mclk);
		save_req <= 1'b0;
		#1;
		chk("save_done", save_done, cat inside {[1:6]});
		chk("save_refused", save_refused, !(cat inside {[1:6]}));
	endtask : sv

	// Status slot must fall back to factory; pass 1 keeps customer slot
	task automatic rdall(input bit cu);
		for (int k = 0; k < NUM_PAR; k++) begin
			rd(k[3:0], v);
			chk("slot", v, (k == 9) ? FACTORY_VALS[9*PW +: PW] :
				(cu && k == 5) ? (pa[k] ^ 16'hFFFF) : pa[k]);
		end
	endtask : rdall

	task automatic cfg();
		wr(PAR_CEIL, c[15:0]);
		wr(PAR_RATED, r[15:0]);
		wr(PAR_PDUR, d[15:0]);
		wr(PAR_PEAK, p[15:0]);
		wr(PAR_SUBMODE, s[15:0]);
		repeat (8) @(posedge mclk);
		#1;
	endtask : cfg

	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge mclk);
		factory_load <= 1'b0;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		for (i = 0; i < NUM_PAR; i++) begin
			rd(i[3:0], v);
			chk("factory", v, FACTORY_VALS[i*PW +: PW]);
		end
		// Corner settings first, then random ones, with no motor load
		for (i = 0; i < 13; i++) begin
			if (i < 5) begin
				r = tab[i][0];
				p = tab[i][1];
				d = tab[i][2];
				c = tab[i][3];
				s = tab[i][4];
			end else begin
				r = 200 + ($random(seed) & 32'h7FF);
				p = 500 + ($random(seed) & 32'h7FF);
				d = $random(seed) & 32'h3;
				c = 500 + ($random(seed) & 32'hFFF);
				s = $random(seed) & 32'h1;
			end
			cfg();
			calc();
			chk("status", stat, act[0]);
			chk("limit", lim, el[15:0]);
			chk("load", acc, 32'h0);
			if (act != 0) begin
				chk("threshold", thr, et[31:0]);
			end
		end
		// Peak current until the clamp engages, then idle until release
		r = 1000;
		p = 2000;
		d = 10;
		c = 3000;
		s = 1;
		cfg();
		@(posedge mclk);
		demand <= 16'h07D0;
		for (n = 0; n < 200 && eng !== 1'b1; n++) begin
			@(posedge mclk);
			#1;
		end
		chk("engage_time", n >= 70 && n <= 95, 1'b1);
		chk("clamp", lim, 16'h03E8);
		chk("thr", thr, 32'h0000001E);
		@(posedge mclk);
		demand <= 16'h0000;
		for (n = 0; n < 400 && eng !== 1'b0; n++) begin
			@(posedge mclk);
			#1;
		end
		repeat (2) @(posedge mclk);
		#1;
		chk("release_time", n < 400, 1'b1);
		chk("release", lim, 16'h07D0);
		chk("drain", acc, 32'h0);
		// Save every category code, scramble, restart firmware
		for (i = 0; i < NUM_PAR; i++) begin
			pa[i] = 16'($random(seed));
			wr(i[3:0], pa[i]);
		end
		for (i = 0; i < 8; i++) begin
			sv(i[2:0]);
		end
		for (i = 0; i < NUM_PAR; i++) begin
			wr(i[3:0], ~pa[i]);
		end
		@(posedge mclk);
		fw_update <= 1'b1;
		@(posedge mclk);
		fw_update <= 1'b0;
		rdall(1'b0);
		// Only the customer group is saved; reset restores the rest
		for (i = 0; i < NUM_PAR; i++) begin
			wr(i[3:0], ~pa[i]);
		end
		sv(3'h3);
		@(posedge mclk);
		reset <= 1'b1;
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		rdall(1'b1);
		print_verdict();
	end

	// Cut a hang short well past the under one thousand cycles expected
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		print_verdict();
	end
endmodule : mocl_top_tb
